// ==== hw/hcec_bus_if.sv ====
`timescale 1ns/100ps
interface hcec_bus_if;
    import hcec_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic upper_address_decode;
    logic mem_io;
    logic bhe_n;
    logic aen;
    logic rfsh_n;
    logic cmd_n;
    logic write_n;
    logic iord_n;
    logic iowr_n;
    logic config_mode_n;
    logic card_disable_n;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe;
    logic [DATA_W-1:0] data;
    logic ds16_n;
    logic rdy;
    logic csfb_n;
    logic option_id_select_n;
    // pulled-up shared data bus
    assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : DATA_IDLE);
    modport device(
        input addr, upper_address_decode, mem_io, bhe_n, aen, rfsh_n, cmd_n, write_n,
        input iord_n, iowr_n, config_mode_n, card_disable_n, data,
        output dev_data, dev_data_oe, ds16_n, rdy, csfb_n, option_id_select_n
    );
    modport host(
        output addr, upper_address_decode, mem_io, bhe_n, aen, rfsh_n, cmd_n, write_n,
        output iord_n, iowr_n, config_mode_n, card_disable_n, host_data, host_data_oe,
        input data, ds16_n, rdy, csfb_n, option_id_select_n
    );
endinterface

// ==== hw/hcec_device.sv ====
// Our own choice: the APB register port.
`timescale 1ns/100ps
// Operation
// RULE_01 - valid decode drives ds16, rdy, card select
// RULE_02 - host gates command with refresh
// RULE_03 - card disable low blocks every access
// RULE_04 - config mode pin low means setup
// RULE_05 - setup mode exposes configuration registers only
// RULE_06 - port 46E8 bit 4 enters setup
// RULE_07 - port 46E8 bit 3 enables card
// RULE_08 - setup access to 100h/101h pulls option id
// RULE_09 - extended registers need both enables set
// RULE_10 - sleep/wake register in setup, bit 0
// RULE_11 - unlock register 103h in setup, bit 7
// RULE_12 - unlock bits 0-4 multi-card and active id
// RULE_13 - multi-card respond only on id match
// RULE_14 - up to sixteen cards, unique ids
// RULE_15 - channel mode dip capture while command low
// RULE_16 - pc mode dip capture while read low
// RULE_17 - software enables, enters setup, wakes, leaves
// RULE_18 - system drives config and disable pins
// RULE_19 - synchronise config and disable pins
module hcec_device
    import hcec_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic pc_bus_strap_i,
    hcec_bus_if.device bus,
    output logic [3:0] status_o
);
    //--------------------------------------------------
    // state
    //--------------------------------------------------
    logic cfg_s1_reg;
    logic cfg_s2_reg;
    logic dis_s1_reg;
    logic dis_s2_reg;
    logic strap_done_reg, strap_done_next;
    logic pc_mode_reg, pc_mode_next;
    logic [7:0] pcse_reg, pcse_next;
    logic [7:0] sw_reg, sw_next;
    logic [7:0] eu_reg, eu_next;
    logic [DIP_W-1:0] dip_reg, dip_next;
    logic [1:0] ext_idx_reg, ext_idx_next;
    logic [7:0] ext_mem_reg [EXT_DEPTH], ext_mem_next [EXT_DEPTH];
    logic strobe_prev_reg, strobe_prev_next;
    logic csfb_n_reg, csfb_n_next;
    logic ds16_n_reg, ds16_n_next;
    logic rdy_reg, rdy_next;
    logic option_id_select_out_n_reg, option_id_select_out_n_next;
    logic [7:0] dd_reg, dd_next;
    logic doe_reg, doe_next;
    logic [3:0] stat_reg, stat_next;
    logic strobe_n;
    logic is_write;
    logic setup_mode;
    logic enabled;
    logic id_match;
    logic ext_ok;
    logic cfg_hit;
    logic option_id_select_out_hit;
    logic pcse_hit;
    logic mem_hit;
    logic vga_hit;
    logic ext_hit;
    logic normal_hit;
    logic respond;
    logic wr_take;
    logic [7:0] rd_val;

    function automatic logic port_hit(input logic [ADDR_W-1:0] a, input logic mem,
                                      input logic [15:0] port);
        port_hit = !mem && (a[15:0] == port);
    endfunction

    //--------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------
    // config and disable levels have no timing to our clock
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cfg_s1_reg <= 1'b1;
            cfg_s2_reg <= 1'b1;
            dis_s1_reg <= 1'b1;
            dis_s2_reg <= 1'b1;
        end
        else
        begin
            cfg_s1_reg <= bus.config_mode_n; // RULE_19
            cfg_s2_reg <= cfg_s1_reg; // RULE_19
            dis_s1_reg <= bus.card_disable_n; // RULE_19
            dis_s2_reg <= dis_s1_reg; // RULE_19
        end
    end

    //--------------------------------------------------
    // decode and register next state
    //--------------------------------------------------
    always_comb
    begin
        strap_done_next = 1'b1;
        pc_mode_next = strap_done_reg ? pc_mode_reg : pc_bus_strap_i;
        strobe_n = pc_mode_reg ? (bus.iord_n & bus.iowr_n) : bus.cmd_n;
        is_write = pc_mode_reg ? !bus.iowr_n : !bus.write_n;
        setup_mode = pc_mode_reg ? pcse_reg[PCSE_SETUP_BIT] : !cfg_s2_reg; // RULE_04 RULE_06
        enabled = pc_mode_reg ? pcse_reg[PCSE_ENABLE_BIT] : dis_s2_reg; // RULE_03 RULE_07
        id_match = !eu_reg[EU_MULTI_BIT] || (dip_reg[ID_W-1:0] == eu_reg[ID_W-1:0]); // RULE_12 RULE_13
        ext_ok = sw_reg[SW_AWAKE_BIT] && eu_reg[EU_EXT_EN_BIT]; // RULE_09
        option_id_select_out_hit = port_hit(bus.addr, bus.mem_io, PORT_OPTION_ID_LO)
                    || port_hit(bus.addr, bus.mem_io, PORT_OPTION_ID_HI);
        cfg_hit = option_id_select_out_hit || port_hit(bus.addr, bus.mem_io, PORT_SLEEP_WAKE)
                  || port_hit(bus.addr, bus.mem_io, PORT_EXT_UNLOCK)
                  || port_hit(bus.addr, bus.mem_io, PORT_DIP_STATE);
        pcse_hit = pc_mode_reg && port_hit(bus.addr, bus.mem_io, PORT_PC_SETUP_ENABLE); // RULE_06
        mem_hit = bus.mem_io && bus.upper_address_decode
                  && (bus.addr[ADDR_W-1:ADDR_W-2] == MEM_WINDOW_A18_A17);
        ext_hit = ext_ok && (port_hit(bus.addr, bus.mem_io, PORT_EXT_INDEX)
                  || port_hit(bus.addr, bus.mem_io, PORT_EXT_DATA)); // RULE_09
        // extension ports only count as display i/o once unlocked
        vga_hit = !bus.mem_io && (bus.addr[15:0] >= PORT_VGA_IO_LO)
                  && (bus.addr[15:0] <= PORT_VGA_IO_HI) && (ext_hit || !(
                  port_hit(bus.addr, bus.mem_io, PORT_EXT_INDEX)
                  || port_hit(bus.addr, bus.mem_io, PORT_EXT_DATA))); // RULE_09
        normal_hit = !setup_mode && sw_reg[SW_AWAKE_BIT] && id_match
                     && (mem_hit || vga_hit || ext_hit); // RULE_05 RULE_10 RULE_13
        respond = pcse_hit || (enabled && ((setup_mode && cfg_hit) || normal_hit)); // RULE_03 RULE_05
        strobe_prev_next = strobe_n;
        wr_take = strobe_prev_reg && !strobe_n && is_write && respond;
        pcse_next = pcse_reg;
        sw_next = sw_reg;
        eu_next = eu_reg;
        ext_idx_next = ext_idx_reg;
        ext_mem_next = ext_mem_reg;
        if (wr_take)
        begin
            if (pcse_hit)
                pcse_next = bus.data; // RULE_06 RULE_07
            else if (setup_mode && port_hit(bus.addr, bus.mem_io, PORT_SLEEP_WAKE))
                sw_next = bus.data; // RULE_10
            else if (setup_mode && port_hit(bus.addr, bus.mem_io, PORT_EXT_UNLOCK))
                eu_next = bus.data; // RULE_11 RULE_12
            else if (ext_hit && port_hit(bus.addr, bus.mem_io, PORT_EXT_INDEX))
                ext_idx_next = bus.data[1:0]; // RULE_09
            else if (ext_hit)
                ext_mem_next[ext_idx_reg] = bus.data; // RULE_09
        end
        dip_next = dip_reg;
        if (!pc_mode_reg && !bus.cmd_n)
            dip_next = {bus.upper_address_decode, bus.addr[18:16], bus.mem_io,
                        dis_s2_reg, bus.bhe_n}; // RULE_15
        else if (pc_mode_reg && !bus.iord_n)
            dip_next = {bus.upper_address_decode, bus.addr[18:16], bus.rfsh_n,
                        bus.aen, bus.bhe_n}; // RULE_16
        rd_val = 8'h00;
        if (pcse_hit)
            rd_val = pcse_reg;
        else if (port_hit(bus.addr, bus.mem_io, PORT_SLEEP_WAKE))
            rd_val = sw_reg;
        else if (port_hit(bus.addr, bus.mem_io, PORT_EXT_UNLOCK))
            rd_val = eu_reg;
        else if (port_hit(bus.addr, bus.mem_io, PORT_DIP_STATE))
            rd_val = {1'b0, dip_reg};
        else if (port_hit(bus.addr, bus.mem_io, PORT_EXT_INDEX))
            rd_val = {6'h00, ext_idx_reg};
        else if (port_hit(bus.addr, bus.mem_io, PORT_EXT_DATA))
            rd_val = ext_mem_reg[ext_idx_reg];
        csfb_n_next = !respond; // RULE_01
        ds16_n_next = !(respond && mem_hit); // RULE_01
        rdy_next = respond && !strobe_n; // RULE_01
        option_id_select_out_n_next = !(enabled && setup_mode && option_id_select_out_hit && !strobe_n); // RULE_08
        // option id data and display memory come from elsewhere
        doe_next = respond && !strobe_n && !is_write && !mem_hit && !(setup_mode && option_id_select_out_hit);
        dd_next = rd_val;
        stat_next = {id_match, ext_ok, sw_reg[SW_AWAKE_BIT], setup_mode};
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            strap_done_reg <= 1'b0;
            pc_mode_reg <= 1'b0;
            pcse_reg <= PCSE_RESET;
            sw_reg <= SW_RESET; // RULE_09
            eu_reg <= EU_RESET; // RULE_09
            dip_reg <= '0;
            ext_idx_reg <= 2'h0;
            for (int i = 0; i < EXT_DEPTH; i++)
                ext_mem_reg[i] <= EXT_RESET;
            strobe_prev_reg <= 1'b1;
            csfb_n_reg <= 1'b1;
            ds16_n_reg <= 1'b1;
            rdy_reg <= 1'b0;
            option_id_select_out_n_reg <= 1'b1;
            dd_reg <= 8'h00;
            doe_reg <= 1'b0;
            stat_reg <= 4'h0;
        end
        else
        begin
            strap_done_reg <= strap_done_next;
            pc_mode_reg <= pc_mode_next;
            pcse_reg <= pcse_next;
            sw_reg <= sw_next;
            eu_reg <= eu_next;
            dip_reg <= dip_next;
            ext_idx_reg <= ext_idx_next;
            ext_mem_reg <= ext_mem_next;
            strobe_prev_reg <= strobe_prev_next;
            csfb_n_reg <= csfb_n_next;
            ds16_n_reg <= ds16_n_next;
            rdy_reg <= rdy_next;
            option_id_select_out_n_reg <= option_id_select_out_n_next;
            dd_reg <= dd_next;
            doe_reg <= doe_next;
            stat_reg <= stat_next;
        end
    end

    //--------------------------------------------------
    // pins
    //--------------------------------------------------
    assign bus.csfb_n = csfb_n_reg;
    assign bus.ds16_n = ds16_n_reg;
    assign bus.rdy = rdy_reg;
    assign bus.option_id_select_n = option_id_select_out_n_reg;
    assign bus.dev_data = dd_reg;
    assign bus.dev_data_oe = doe_reg;
    assign status_o = stat_reg;
endmodule // hcec_device

// ==== hw/hcec_host.sv ====
`timescale 1ns/100ps
module hcec_host
    import hcec_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic refresh_req_i,
    hcec_bus_if.host bus
);
    //--------------------------------------------------
    // state
    //--------------------------------------------------
    hcec_host_state_type state_reg, state_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [31:0] cmd_reg, cmd_next;
    logic [7:0] wd_reg, wd_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [3:0] seen_reg, seen_next;
    logic [7:0] rcap_reg, rcap_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic rfsh_n_reg, rfsh_n_next;
    logic cmd_n_reg, cmd_n_next;
    logic iord_n_reg, iord_n_next;
    logic iowr_n_reg, iowr_n_next;
    logic hoe_reg, hoe_next;
    logic access;
    logic mapped;
    logic stall;
    logic commit;
    logic strobe;
    logic [31:0] rd_val;

    //--------------------------------------------------
    // apb slave and cycle sequencer
    //--------------------------------------------------
    always_comb
    begin
        access = psel_i && penable_i;
        mapped = (paddr_i == APB_CTRL) || (paddr_i == APB_CMD)
                 || (paddr_i == APB_WDATA) || (paddr_i == APB_STATUS);
        // a new cycle order waits until the previous one is over
        stall = pwrite_i && (paddr_i == APB_CMD) && (state_reg != HS_IDLE);
        commit = access && pready_reg && pwrite_i && mapped && !pslverr_reg;
        case (paddr_i)
            APB_CTRL: rd_val = {29'h0, ctrl_reg};
            APB_CMD: rd_val = cmd_reg;
            APB_WDATA: rd_val = {24'h0, wd_reg};
            APB_STATUS: rd_val = {16'h0, rcap_reg, 3'h0, seen_reg, state_reg != HS_IDLE};
            default: rd_val = 32'h0;
        endcase
        pready_next = access && !pready_reg && !stall;
        pslverr_next = access && !pready_reg && !stall && !mapped;
        prdata_next = (access && !pready_reg && !pwrite_i) ? rd_val : prdata_reg;
        ctrl_next = ctrl_reg;
        wd_next = wd_reg;
        cmd_next = cmd_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        seen_next = seen_reg;
        rcap_next = rcap_reg;
        if (commit && paddr_i == APB_CTRL)
            ctrl_next = pwdata_i[2:0];
        if (commit && paddr_i == APB_WDATA)
            wd_next = pwdata_i[7:0];
        case (state_reg)
            HS_IDLE:
            begin
                if (commit && paddr_i == APB_CMD)
                begin
                    cmd_next = pwdata_i;
                    cnt_next = 3'h0;
                    seen_next = 4'h0;
                    state_next = HS_ADDR;
                end
            end
            HS_ADDR:
            begin
                if (cnt_reg < HOST_ADDR_CYCLES - 3'h1)
                    cnt_next = cnt_reg + 3'h1;
                else if (!refresh_req_i)
                begin
                    cnt_next = 3'h0;
                    state_next = HS_STROBE;
                end
            end
            HS_STROBE:
            begin
                seen_next = seen_reg | {bus.rdy, !bus.ds16_n, !bus.option_id_select_n, !bus.csfb_n};
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == HOST_CMD_CYCLES - 3'h1)
                begin
                    rcap_next = bus.data;
                    state_next = HS_DONE;
                end
            end
            HS_DONE: state_next = HS_IDLE;
            default: state_next = HS_IDLE;
        endcase
        strobe = (state_next == HS_STROBE);
        // refresh is deferred while a command strobe is out
        rfsh_n_next = !(refresh_req_i && !strobe); // RULE_02
        cmd_n_next = !(strobe && rfsh_n_next && !ctrl_reg[CTRL_PC_MODE_BIT]); // RULE_02
        iord_n_next = !(strobe && ctrl_reg[CTRL_PC_MODE_BIT] && !cmd_next[CMD_WRITE_BIT]);
        iowr_n_next = !(strobe && ctrl_reg[CTRL_PC_MODE_BIT] && cmd_next[CMD_WRITE_BIT]);
        hoe_next = cmd_next[CMD_WRITE_BIT] && (state_next == HS_ADDR || strobe);
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= HS_IDLE;
            ctrl_reg <= CTRL_RESET;
            cmd_reg <= 32'h0;
            wd_reg <= 8'h00;
            cnt_reg <= 3'h0;
            seen_reg <= 4'h0;
            rcap_reg <= 8'h00;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            rfsh_n_reg <= 1'b1;
            cmd_n_reg <= 1'b1;
            iord_n_reg <= 1'b1;
            iowr_n_reg <= 1'b1;
            hoe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            cmd_reg <= cmd_next;
            wd_reg <= wd_next;
            cnt_reg <= cnt_next;
            seen_reg <= seen_next;
            rcap_reg <= rcap_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            rfsh_n_reg <= rfsh_n_next;
            cmd_n_reg <= cmd_n_next;
            iord_n_reg <= iord_n_next;
            iowr_n_reg <= iowr_n_next;
            hoe_reg <= hoe_next;
        end
    end

    //--------------------------------------------------
    // pins
    //--------------------------------------------------
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign bus.addr = cmd_reg[ADDR_W-1:0];
    assign bus.upper_address_decode = cmd_reg[CMD_UPPER_BIT];
    assign bus.mem_io = cmd_reg[CMD_MEM_BIT];
    assign bus.write_n = !cmd_reg[CMD_WRITE_BIT];
    assign bus.bhe_n = cmd_reg[CMD_BHE_N_BIT];
    assign bus.aen = 1'b0;
    assign bus.rfsh_n = rfsh_n_reg;
    assign bus.cmd_n = cmd_n_reg;
    assign bus.iord_n = iord_n_reg;
    assign bus.iowr_n = iowr_n_reg;
    // pins the system logic drives in channel mode only
    assign bus.config_mode_n = !(ctrl_reg[CTRL_SETUP_BIT] && !ctrl_reg[CTRL_PC_MODE_BIT]); // RULE_18
    assign bus.card_disable_n = ctrl_reg[CTRL_ENABLE_BIT] || ctrl_reg[CTRL_PC_MODE_BIT]; // RULE_18
    assign bus.host_data = wd_reg;
    assign bus.host_data_oe = hoe_reg;
endmodule // hcec_host

// ==== hw/hcec_pkg.sv ====
package hcec_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int DIP_W = 7;
    localparam int ID_W = 4;
    localparam int EXT_DEPTH = 4;
    // device i/o ports and memory window
    localparam logic [15:0] PORT_OPTION_ID_LO = 16'h0100;
    localparam logic [15:0] PORT_OPTION_ID_HI = 16'h0101;
    localparam logic [15:0] PORT_SLEEP_WAKE = 16'h0102;
    localparam logic [15:0] PORT_EXT_UNLOCK = 16'h0103;
    localparam logic [15:0] PORT_DIP_STATE = 16'h0104;
    localparam logic [15:0] PORT_PC_SETUP_ENABLE = 16'h46E8;
    localparam logic [15:0] PORT_EXT_INDEX = 16'h03D6;
    localparam logic [15:0] PORT_EXT_DATA = 16'h03D7;
    localparam logic [15:0] PORT_VGA_IO_LO = 16'h03B0;
    localparam logic [15:0] PORT_VGA_IO_HI = 16'h03DF;
    localparam logic [1:0] MEM_WINDOW_A18_A17 = 2'h1;
    // device field positions and reset values
    localparam int PCSE_ENABLE_BIT = 3;
    localparam int PCSE_SETUP_BIT = 4;
    localparam int SW_AWAKE_BIT = 0;
    localparam int EU_EXT_EN_BIT = 7;
    localparam int EU_MULTI_BIT = 4;
    localparam logic [7:0] PCSE_RESET = 8'h00;
    localparam logic [7:0] SW_RESET = 8'h00;
    localparam logic [7:0] EU_RESET = 8'h00;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [7:0] DATA_IDLE = 8'hFF;
    // host apb map
    localparam logic [11:0] APB_CTRL = 12'h000;
    localparam logic [11:0] APB_CMD = 12'h004;
    localparam logic [11:0] APB_WDATA = 12'h008;
    localparam logic [11:0] APB_STATUS = 12'h00C;
    localparam int CTRL_PC_MODE_BIT = 0;
    localparam int CTRL_SETUP_BIT = 1;
    localparam int CTRL_ENABLE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int CMD_UPPER_BIT = 19;
    localparam int CMD_MEM_BIT = 20;
    localparam int CMD_WRITE_BIT = 21;
    localparam int CMD_BHE_N_BIT = 22;
    localparam logic [2:0] HOST_ADDR_CYCLES = 3'h2;
    localparam logic [2:0] HOST_CMD_CYCLES = 3'h4;
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_ADDR = 4'h2,
        HS_STROBE = 4'h4,
        HS_DONE = 4'h8
    } hcec_host_state_type;
endpackage

// ==== sim/hcec_monitor.sv ====
`timescale 1ns/100ps
module hcec_monitor
    import hcec_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic upper_address_decode,
    input wire logic mem_io,
    input wire logic rfsh_n,
    input wire logic cmd_n,
    input wire logic write_n,
    input wire logic iord_n,
    input wire logic iowr_n,
    input wire logic config_mode_n,
    input wire logic card_disable_n,
    input wire logic dev_data_oe,
    input wire logic ds16_n,
    input wire logic rdy,
    input wire logic csfb_n,
    input wire logic option_id_select_n
);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wire logic strobe_low = !cmd_n || !iord_n || !iowr_n;
    // four samples cover the two-stage synchroniser plus the decode flop
    sequence s_disabled; !card_disable_n [*4]; endsequence
    sequence s_setup; !config_mode_n [*4]; endsequence
    sequence s_idle; !strobe_low [*2]; endsequence
    property p_dis; s_disabled |-> csfb_n && !rdy; endproperty
    property p_setup_mem; s_setup |-> ds16_n; endproperty
    property p_idle; s_idle |-> !rdy && !dev_data_oe; endproperty
    property p_rdy; $rose(rdy) |-> $past(strobe_low) && !csfb_n; endproperty
    property p_ds16;
        !ds16_n |-> $past(mem_io && upper_address_decode && addr[18:17] == MEM_WINDOW_A18_A17);
    endproperty
    property p_optid;
        !option_id_select_n |-> !mem_io && addr[15:1] == 15'h0080 && ($past(strobe_low) || strobe_low);
    endproperty
    property p_oe; dev_data_oe |-> write_n && rdy; endproperty
    property p_rfsh; !rfsh_n |-> cmd_n; endproperty
    a_dis: assert property (p_dis) else $error("disabled card answered");
    a_setup_mem: assert property (p_setup_mem) else $error("memory selected in setup");
    a_idle: assert property (p_idle) else $error("rdy or data held after strobe");
    a_rdy: assert property (p_rdy) else $error("rdy without strobe or select");
    a_ds16: assert property (p_ds16) else $error("ds16 outside memory window");
    a_optid: assert property (p_optid) else $error("option id select on wrong port");
    a_oe: assert property (p_oe) else $error("device drives data outside read");
    a_rfsh: assert property (p_rfsh) else $error("command during refresh");
endmodule // hcec_monitor

// ==== sim/host_config_enable_control_bench.sv ====
`timescale 1ns/100ps
module host_config_enable_control_bench
    import hcec_pkg::*;
;
    logic mclk_i, reset_i, strap, psel, penable, pwrite, refresh_req, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] status;
    int miscompares, check_count;
    hcec_bus_if bus();
    hcec_device u_hcec_device(.mclk_i(mclk_i), .reset_i(reset_i), .pc_bus_strap_i(strap), .bus(bus.device),
        .status_o(status));
    hcec_host u_hcec_host(.mclk_i(mclk_i), .reset_i(reset_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .refresh_req_i(refresh_req), .bus(bus.host));
    hcec_monitor u_hcec_monitor(.mclk_i(mclk_i), .reset_i(reset_i), .addr(bus.addr),
        .upper_address_decode(bus.upper_address_decode), .mem_io(bus.mem_io), .rfsh_n(bus.rfsh_n),
        .cmd_n(bus.cmd_n), .write_n(bus.write_n), .iord_n(bus.iord_n), .iowr_n(bus.iowr_n),
        .config_mode_n(bus.config_mode_n), .card_disable_n(bus.card_disable_n), .dev_data_oe(bus.dev_data_oe),
        .ds16_n(bus.ds16_n), .rdy(bus.rdy), .csfb_n(bus.csfb_n), .option_id_select_n(bus.option_id_select_n));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one host bus cycle; leaves the final status word in rd
    task cyc(input logic [18:0] a, input logic mem, input logic wr, input logic [7:0] wd);
        apb(APB_WDATA, 1'b1, {24'h0, wd});
        apb(APB_CMD, 1'b1, {9'h0, 1'b0, wr, mem, mem, a});
        do apb(APB_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task do_reset(input logic pc);
        reset_i <= 1'b1;
        strap <= pc;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_map;
        apb(APB_CTRL, 1'b0, 32'h0);
        check(rd, {29'h0, CTRL_RESET});
        apb(12'h010, 1'b1, 32'h1);
        check(err, 1'b1);
        check(status, 4'h8);
    endtask
    task t_channel;
        cyc(19'h003B0, 1'b0, 1'b0, 8'h00);
        check(rd[1], 1'b0);
        apb(APB_CTRL, 1'b1, 32'h6);
        cyc(19'h00100, 1'b0, 1'b0, 8'h00);
        check(rd[2], 1'b1);
        check(rd[15:8], DATA_IDLE);
        cyc(19'h00102, 1'b0, 1'b1, 8'h01);
        cyc(19'h00103, 1'b0, 1'b1, 8'h80);
        check(status[2:0], 3'h7);
        cyc(19'h20000, 1'b1, 1'b0, 8'h00);
        check(rd[3], 1'b0);
        apb(APB_CTRL, 1'b1, 32'h4);
        cyc(19'h20000, 1'b1, 1'b0, 8'h00);
        check(rd[3], 1'b1);
        check(status[0], 1'b0);
        cyc(19'h00102, 1'b0, 1'b0, 8'h00);
        check(rd[1], 1'b0);
        cyc(19'h003D6, 1'b0, 1'b1, 8'h01);
        cyc(19'h003D7, 1'b0, 1'b1, 8'h5A);
        cyc(19'h003D7, 1'b0, 1'b0, 8'h00);
        check(rd[15:8], 8'h5A);
        refresh_req <= 1'b1;
        apb(APB_CMD, 1'b1, 32'h000003B0);
        repeat (10) @(posedge mclk_i);
        check(bus.cmd_n, 1'b1);
        refresh_req <= 1'b0;
        do apb(APB_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task t_multi;
        apb(APB_CTRL, 1'b1, 32'h6);
        cyc(19'h00103, 1'b0, 1'b1, 8'h9F);
        apb(APB_CTRL, 1'b1, 32'h4);
        cyc(19'h003B0, 1'b0, 1'b0, 8'h00);
        check(rd[1], 1'b0);
        check(status[3], 1'b0);
        apb(APB_CTRL, 1'b1, 32'h6);
        cyc(19'h00103, 1'b0, 1'b1, 8'h92);
        // io access in channel mode with card enabled and bhe low: switch state 02
        cyc(19'h00104, 1'b0, 1'b0, 8'h00);
        check(rd[15:8], 8'h02);
        apb(APB_CTRL, 1'b1, 32'h4);
        cyc(19'h003B0, 1'b0, 1'b0, 8'h00);
        check(rd[1], 1'b1);
    endtask
    task t_pc;
        do_reset(1'b1);
        apb(APB_CTRL, 1'b1, 32'h1);
        cyc(19'h046E8, 1'b0, 1'b1, 8'h18);
        check(status[0], 1'b1);
        // pc mode switch word: rfsh_n high, aen and bhe_n low
        cyc(19'h00104, 1'b0, 1'b0, 8'h00);
        check(rd[15:8], 8'h04);
        cyc(19'h00102, 1'b0, 1'b1, 8'h01);
        cyc(19'h046E8, 1'b0, 1'b1, 8'h08);
        check(status[1:0], 2'h2);
        cyc(19'h003B0, 1'b0, 1'b0, 8'h00);
        check(rd[1], 1'b1);
        cyc(19'h046E8, 1'b0, 1'b1, 8'h00);
        cyc(19'h003B0, 1'b0, 1'b0, 8'h00);
        check(rd[1], 1'b0);
    endtask
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial
    begin
        repeat (40000) @(posedge mclk_i);
        miscompares++;
        give_verdict;
    end
    initial
    begin
        {reset_i, strap, psel, penable, pwrite, refresh_req} = 6'h20;
        paddr = 12'h000;
        pwdata = 32'h0;
        miscompares = 0;
        check_count = 0;
        do_reset(1'b0);
        t_map;
        t_channel;
        t_multi;
        t_pc;
        give_verdict;
    end
endmodule // host_config_enable_control_bench
